//--- src/rops_pkg.sv
// constants, register map and source encodings of the output pin selection block
// assumes one 20 MHz clock, synchronous reset and a classic wishbone register port
// Notes on behaviour
// - secondary pin is open drain; its source comes from the auxiliary output select field.
// - one select value puts the stored auxiliary static level on the secondary pin.
// - one select value puts the square wave there, only while square wave enable is set.
// - one select value drives the inverse of the combined interrupt, active low.
// - one select value drives the inverse of the alarm interrupt.
// - the timer interrupt can appear on the secondary pin true or inverted.
// - with switch mode set the secondary pin acts as a power switch, not logic.
// - timer interrupt pin is open drain and always carries the active-low timer interrupt.
// - clock output pin is push-pull and presents exactly one of two sources.
// - one clock output choice is the stored primary static level.
// - the other choice is the square wave, present only while enabled.
// - reset output is open drain; its asserted level follows the polarity bit.
// - reset polarity clears to zero at reset, giving an active-low reset output.
// - external reset low with its enable set asserts the reset output.
package rops_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL2 = 6'h11;
  localparam logic [5:0] IDX_SQCFG    = 6'h13;
  localparam logic [5:0] IDX_CONFIG   = 6'h14;
  localparam logic [5:0] IDX_STATUS   = 6'h15;
  localparam logic [5:0] IDX_MASK     = 6'h16;
  localparam logic [5:0] IDX_PINS     = 6'h17;

  // control2 fields
  localparam int CTL2_SEL_LSB   = 2;
  localparam int CTL2_SEL_W     = 3;
  localparam int CTL2_SWITCH    = 5;
  // square wave register field
  localparam int SQ_ENABLE      = 7;
  // config fields
  localparam int CFG_PRI_LEVEL  = 0;
  localparam int CFG_AUX_LEVEL  = 1;
  localparam int CFG_CLK_SEL    = 2;
  localparam int CFG_RST_POL    = 3;
  localparam int CFG_EXT_RST_EN = 4;
  // status and mask fields
  localparam int EVT_RESET      = 0;
  localparam int EVT_TIMER      = 1;
  localparam int EVT_ALARM      = 2;
  localparam int EVT_W          = 3;

  // values after reset
  localparam logic [7:0] CONTROL2_RST = 8'h00;
  localparam logic [7:0] SQCFG_RST    = 8'h00;
  localparam logic [7:0] CONFIG_RST   = 8'h00;
  localparam logic [2:0] STATUS_RST   = 3'h0;
  localparam logic [2:0] MASK_RST     = 3'h0;

  // auxiliary output select encodings
  typedef enum logic [2:0] {
    AUX_STATIC    = 3'h0,
    AUX_IRQ_N     = 3'h1,
    AUX_SQUARE    = 3'h2,
    AUX_ALARM_N   = 3'h3,
    AUX_TIMER     = 3'h4,
    AUX_TIMER_N   = 3'h5
  } rops_aux_sel_t;

  // synchroniser idle level for the external reset pin (released high)
  localparam logic SYNC_RST_VAL = 1'b1;

endpackage : rops_pkg

//--- src/rops_sync2.sv
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to mclk_in; reset loads a constant idle level
module rops_sync2
  import rops_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic pin_in,
  output logic      sync_out
);

  logic meta;
  logic next_meta;
  logic next_sync;

  // only the second flop reads the first
  always_comb begin
    next_meta = pin_in;
    next_sync = meta;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      meta     <= SYNC_RST_VAL;
      sync_out <= SYNC_RST_VAL;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end

endmodule : rops_sync2

//--- src/rops_od_drv.sv
// open-drain driver: registered enable that pulls the pin low
// assumes an external pull-up sets the high level
module rops_od_drv
  import rops_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic level_in,
  output logic      oe_out
);

  logic next_oe;

  // drive only for a low level, float for high
  always_comb begin
    next_oe = ~level_in;
  end

  // reset releases the pin
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      oe_out <= 1'b0;
    end else begin
      oe_out <= next_oe;
    end
  end

endmodule : rops_od_drv

//--- src/rops_top.sv
// output pin selection: secondary irq/switch pin, timer irq pin, clock out, reset out
// assumes irq and square wave sources come from logic on mclk_in; ext_reset_in is a pin
// assumes a pull-up on every open-drain pin, so a released line reads high
module rops_top
  import rops_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  // wishbone classic slave
  input  wire logic       wb_cyc_in,
  input  wire logic       wb_stb_in,
  input  wire logic       wb_we_in,
  input  wire logic [7:0] wb_adr_in,
  input  wire logic [3:0] wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]     wb_dat_out,
  output logic            wb_ack_out,
  // internal sources
  input  wire logic       square_wave_in,
  input  wire logic       combined_irq_in,
  input  wire logic       alarm_interrupt_in,
  input  wire logic       timer_interrupt_in,
  // external reset pin, active low
  input  wire logic       ext_reset_in,
  // pins
  output logic            aux_irq_switch_pin_out,
  output logic            aux_irq_switch_pin_oe_out,
  output logic            aux_switch_mode_out,
  output logic            timer_irq_pin_out,
  output logic            timer_irq_pin_oe_out,
  output logic            clock_out_pin_out,
  output logic            reset_out_pin_out,
  output logic            reset_out_pin_oe_out,
  output logic            irq_out
);

  // register state
  logic [7:0]      control2;
  logic [7:0]      square_cfg;
  logic [7:0]      config_reg;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic [7:0]      next_control2;
  logic [7:0]      next_square_cfg;
  logic [7:0]      next_config_reg;
  logic [EVT_W-1:0] next_status;
  logic [EVT_W-1:0] next_mask;

  // bus state
  logic            next_ack;
  logic [31:0]     next_dat;

  // pin and event state
  logic            ext_reset_sync;
  logic            aux_level;
  logic            next_aux_level;
  logic            timer_level;
  logic            next_timer_level;
  logic            reset_level;
  logic            next_reset_level;
  logic            next_clock_out;
  logic            next_switch_mode;
  logic            reset_asserted;
  logic            timer_prev;
  logic            alarm_prev;
  logic            reset_prev;
  logic            next_irq;
  logic [EVT_W-1:0] events;

  // edge detector next values
  logic            next_timer_prev;
  logic            next_alarm_prev;
  logic            next_reset_prev;

  logic [5:0]      bus_idx;
  logic            bus_req;
  logic            bus_wr;
  logic            aux_oe_raw;
  logic            timer_oe_raw;
  logic            reset_oe_raw;

  // gated square wave, used by both selectable pins
  function automatic logic gated_square(input logic sq, input logic [7:0] sqcfg);
    gated_square = sq & sqcfg[SQ_ENABLE];
  endfunction : gated_square

  // write merge for byte lane 0; other lanes hold nothing
  function automatic logic [7:0] lane0_write(input logic [7:0] old_val, input logic [3:0] sel,
                                             input logic [31:0] wdat);
    lane0_write = sel[0] ? wdat[7:0] : old_val;
  endfunction : lane0_write

  assign bus_idx = wb_adr_in[7:2];
  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign bus_wr  = bus_req & wb_we_in;

  // external reset pin passes two flops first
  rops_sync2 u_ext_reset_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (ext_reset_in),
    .sync_out   (ext_reset_sync)
  );

  // external reset request: pin low and enabled
  assign reset_asserted = ~ext_reset_sync & config_reg[CFG_EXT_RST_EN];

  // rising edges of the timer and alarm interrupts and of the reset request are events
  assign events[EVT_RESET] = reset_asserted & ~reset_prev;
  assign events[EVT_TIMER] = timer_interrupt_in & ~timer_prev;
  assign events[EVT_ALARM] = alarm_interrupt_in & ~alarm_prev;

  // register next values; a new event beats a write-one clear
  always_comb begin
    next_control2   = control2;
    next_square_cfg = square_cfg;
    next_config_reg = config_reg;
    next_mask       = mask;
    next_status     = status;
    if (bus_wr) begin
      if (bus_idx == IDX_CONTROL2) begin
        next_control2 = lane0_write(control2, wb_sel_in, wb_dat_in);
      end else if (bus_idx == IDX_SQCFG) begin
        next_square_cfg = lane0_write(square_cfg, wb_sel_in, wb_dat_in);
      end else if (bus_idx == IDX_CONFIG) begin
        next_config_reg = lane0_write(config_reg, wb_sel_in, wb_dat_in);
      end else if (bus_idx == IDX_MASK) begin
        if (wb_sel_in[0]) begin
          next_mask = wb_dat_in[EVT_W-1:0];
        end
      end else if (bus_idx == IDX_STATUS) begin
        if (wb_sel_in[0]) begin
          next_status = status & ~wb_dat_in[EVT_W-1:0];
        end
      end
    end
    next_status = next_status | events;
  end

  // registers; polarity and every field clear at reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      control2   <= CONTROL2_RST;
      square_cfg <= SQCFG_RST;
      config_reg <= CONFIG_RST;
      mask       <= MASK_RST;
      status     <= STATUS_RST;
    end else begin
      control2   <= next_control2;
      square_cfg <= next_square_cfg;
      config_reg <= next_config_reg;
      mask       <= next_mask;
      status     <= next_status;
    end
  end

  // read mux and one-cycle ack; unmapped reads return zero but still ack
  always_comb begin
    next_ack = bus_req;
    next_dat = 32'h0000_0000;
    if (bus_req && !wb_we_in) begin
      if (bus_idx == IDX_CONTROL2) begin
        next_dat[7:0] = control2;
      end else if (bus_idx == IDX_SQCFG) begin
        next_dat[7:0] = square_cfg;
      end else if (bus_idx == IDX_CONFIG) begin
        next_dat[7:0] = config_reg;
      end else if (bus_idx == IDX_STATUS) begin
        next_dat[EVT_W-1:0] = status;
      end else if (bus_idx == IDX_MASK) begin
        next_dat[EVT_W-1:0] = mask;
      end else if (bus_idx == IDX_PINS) begin
        next_dat[5:0] = {ext_reset_sync, irq_out, reset_level, clock_out_pin_out, timer_level, aux_level};
      end
    end
  end

  // ack drops the cycle after it was given
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= next_ack;
      wb_dat_out <= next_dat;
    end
  end

  // pin level selection
  always_comb begin
    next_aux_level = config_reg[CFG_AUX_LEVEL];
    case (rops_aux_sel_t'(control2[CTL2_SEL_LSB +: CTL2_SEL_W]))
      AUX_STATIC:  next_aux_level = config_reg[CFG_AUX_LEVEL];
      AUX_IRQ_N:   next_aux_level = ~combined_irq_in;
      AUX_SQUARE:  next_aux_level = gated_square(square_wave_in, square_cfg);
      AUX_ALARM_N: next_aux_level = ~alarm_interrupt_in;
      AUX_TIMER:   next_aux_level = timer_interrupt_in;
      AUX_TIMER_N: next_aux_level = ~timer_interrupt_in;
      default:     next_aux_level = config_reg[CFG_AUX_LEVEL];
    endcase
    // switch mode: closed (pin pulled to ground) while the static level is low
    next_switch_mode = control2[CTL2_SWITCH];
    if (control2[CTL2_SWITCH]) begin
      next_aux_level = config_reg[CFG_AUX_LEVEL];
    end
    // timer pin has no alternative source
    next_timer_level = ~timer_interrupt_in;
    // clock output: static level or gated square, one at a time
    if (config_reg[CFG_CLK_SEL]) begin
      next_clock_out = gated_square(square_wave_in, square_cfg);
    end else begin
      next_clock_out = config_reg[CFG_PRI_LEVEL];
    end
    // asserted level equals the polarity bit
    next_reset_level = reset_asserted ? config_reg[CFG_RST_POL] : ~config_reg[CFG_RST_POL];
  end

  // pin levels registered; released state after reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      aux_level           <= 1'b1;
      timer_level         <= 1'b1;
      reset_level         <= 1'b1;
      clock_out_pin_out   <= 1'b0;
      aux_switch_mode_out <= 1'b0;
    end else begin
      aux_level           <= next_aux_level;
      timer_level         <= next_timer_level;
      reset_level         <= next_reset_level;
      clock_out_pin_out   <= next_clock_out;
      aux_switch_mode_out <= next_switch_mode;
    end
  end

  // edge detectors track the previous source level
  always_comb begin
    next_timer_prev = timer_interrupt_in;
    next_alarm_prev = alarm_interrupt_in;
    next_reset_prev = reset_asserted;
  end

  // idle low after reset, matching the sources, so reset makes no false edge
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      timer_prev <= 1'b0;
      alarm_prev <= 1'b0;
      reset_prev <= 1'b0;
    end else begin
      timer_prev <= next_timer_prev;
      alarm_prev <= next_alarm_prev;
      reset_prev <= next_reset_prev;
    end
  end

  // level interrupt from the status bits as they stand after this edge,
  // so a write-one clear and the interrupt drop together
  always_comb begin
    next_irq = |(next_status & mask);
  end

  // interrupt output flop
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= next_irq;
    end
  end

  // open-drain stages; data lines of those pins only ever carry low
  rops_od_drv u_aux_od (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .level_in   (aux_level),
    .oe_out     (aux_oe_raw)
  );

  rops_od_drv u_timer_od (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .level_in   (timer_level),
    .oe_out     (timer_oe_raw)
  );

  rops_od_drv u_reset_od (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .level_in   (reset_level),
    .oe_out     (reset_oe_raw)
  );

  // enables come straight from the driver flops
  assign aux_irq_switch_pin_oe_out = aux_oe_raw;
  assign timer_irq_pin_oe_out      = timer_oe_raw;
  assign reset_out_pin_oe_out      = reset_oe_raw;
  // pull-low only: data flops hold low, high comes from the pull-up
  always_ff @(posedge mclk_in) begin
    aux_irq_switch_pin_out <= 1'b0;
    timer_irq_pin_out      <= 1'b0;
    reset_out_pin_out      <= 1'b0;
  end

endmodule : rops_top

//--- tb/rops_host_model.sv
// host side of the pins: pull-ups on the open-drain lines
// assumes the design pulls a line low only while its enable is high
module rops_host_model (
  input  wire logic aux_oe_in,
  input  wire logic aux_pin_in,
  input  wire logic tmr_oe_in,
  input  wire logic tmr_pin_in,
  input  wire logic rst_oe_in,
  input  wire logic rst_pin_in,
  output logic      aux_lvl_out,
  output logic      tmr_lvl_out,
  output logic      rst_lvl_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released line floats up to the pull-up, never holds the last value
  assign aux_lvl_out = aux_oe_in ? aux_pin_in : 1'b1;
  assign tmr_lvl_out = tmr_oe_in ? tmr_pin_in : 1'b1;
  assign rst_lvl_out = rst_oe_in ? rst_pin_in : 1'b1;
endmodule : rops_host_model

//--- tb/rops_top_assertions.sv
// checker for the pin selection block, bound to rops_top
// assumes one clock; shadows the steering registers from bus writes
module rops_top_assertions
  import rops_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        square_wave_in,
  input wire logic        combined_irq_in,
  input wire logic        alarm_interrupt_in,
  input wire logic        timer_interrupt_in,
  input wire logic        ext_reset_in,
  input wire logic        aux_irq_switch_pin_out,
  input wire logic        aux_irq_switch_pin_oe_out,
  input wire logic        aux_switch_mode_out,
  input wire logic        timer_irq_pin_out,
  input wire logic        timer_irq_pin_oe_out,
  input wire logic        clock_out_pin_out,
  input wire logic        reset_out_pin_out,
  input wire logic        reset_out_pin_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctl2, sq_cfg, cfg, next_ctl2, next_sq_cfg, next_cfg;
  logic [2:0] q, next_q;
  logic       ext_d, req, aux_sel, clk_sel;
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  // shadow registers; ext pin edges restart the settle count (longer path)
  always_comb begin
    next_ctl2 = ctl2;
    next_sq_cfg = sq_cfg;
    next_cfg = cfg;
    if (req && wb_we_in && wb_sel_in[0]) begin
      if (wb_adr_in[7:2] == IDX_CONTROL2) next_ctl2 = wb_dat_in[7:0];
      if (wb_adr_in[7:2] == IDX_SQCFG) next_sq_cfg = wb_dat_in[7:0];
      if (wb_adr_in[7:2] == IDX_CONFIG) next_cfg = wb_dat_in[7:0];
    end
    next_q = (ext_reset_in != ext_d) ? 3'h0 : q + {2'h0, q != 3'h7};
  end
  always_ff @(posedge mclk_in) begin
    ext_d <= ext_reset_in;
    ctl2 <= sys_rst_in ? CONTROL2_RST : next_ctl2;
    sq_cfg <= sys_rst_in ? SQCFG_RST : next_sq_cfg;
    cfg <= sys_rst_in ? CONFIG_RST : next_cfg;
    q <= sys_rst_in ? 3'h0 : next_q;
  end
  // expected pin sources; switch mode overrides the select field
  always_comb begin
    clk_sel = cfg[CFG_CLK_SEL] ? (sq_cfg[SQ_ENABLE] && square_wave_in) : cfg[CFG_PRI_LEVEL];
    case (ctl2[CTL2_SEL_LSB +: CTL2_SEL_W])
      AUX_IRQ_N:   aux_sel = !combined_irq_in;
      AUX_SQUARE:  aux_sel = sq_cfg[SQ_ENABLE] && square_wave_in;
      AUX_ALARM_N: aux_sel = !alarm_interrupt_in;
      AUX_TIMER:   aux_sel = timer_interrupt_in;
      AUX_TIMER_N: aux_sel = !timer_interrupt_in;
      default:     aux_sel = cfg[CFG_AUX_LEVEL];
    endcase
    if (ctl2[CTL2_SWITCH]) aux_sel = cfg[CFG_AUX_LEVEL];
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  property p_aux_pin; q >= 3'h3 |-> aux_irq_switch_pin_oe_out == !$past(aux_sel, 2); endproperty
  a_aux_pin: assert property (p_aux_pin) else $error("aux pin enable wrong");
  property p_timer_pin; q >= 3'h3 |-> timer_irq_pin_oe_out == $past(timer_interrupt_in, 2); endproperty
  a_timer_pin: assert property (p_timer_pin) else $error("timer pin enable wrong");
  property p_clk_out; q >= 3'h2 |-> clock_out_pin_out == $past(clk_sel); endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock out wrong");
  property p_rst_pin;
    q >= 3'h4 && ext_reset_in == ext_d |-> reset_out_pin_oe_out ==
      ((!ext_reset_in && $past(cfg[CFG_EXT_RST_EN], 2)) ^ $past(cfg[CFG_RST_POL], 2));
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin enable wrong");
  property p_switch; $rose(ctl2[CTL2_SWITCH]) |-> ##[0:2] aux_switch_mode_out; endproperty
  a_switch: assert property (p_switch) else $error("switch mode not entered");
  property p_od_low; !aux_irq_switch_pin_out && !timer_irq_pin_out && !reset_out_pin_out; endproperty
  a_od_low: assert property (p_od_low) else $error("open drain data not low");
  property p_ack; req |=> wb_ack_out ##1 !wb_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_ack_cause; wb_ack_out |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !wb_ack_out |-> wb_dat_out == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
endmodule : rops_top_assertions
bind rops_top rops_top_assertions u_chk (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .square_wave_in(square_wave_in),
  .combined_irq_in(combined_irq_in), .alarm_interrupt_in(alarm_interrupt_in),
  .timer_interrupt_in(timer_interrupt_in), .ext_reset_in(ext_reset_in),
  .aux_irq_switch_pin_out(aux_irq_switch_pin_out), .aux_irq_switch_pin_oe_out(aux_irq_switch_pin_oe_out),
  .aux_switch_mode_out(aux_switch_mode_out), .timer_irq_pin_out(timer_irq_pin_out),
  .timer_irq_pin_oe_out(timer_irq_pin_oe_out), .clock_out_pin_out(clock_out_pin_out),
  .reset_out_pin_out(reset_out_pin_out), .reset_out_pin_oe_out(reset_out_pin_oe_out));

//--- tb/tb.sv
// self-checking bench for the pin selection block
// assumes the host model supplies the pull-ups on the open-drain lines
module tb
  import rops_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] ctl2;
    logic [7:0] cfg;
    logic [7:0] sq;
    logic [3:0] src;
    logic [1:0] res;
  } rops_row_t;
  logic        mclk_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [7:0]  wb_adr_in, rd;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic        square_wave_in, combined_irq_in, alarm_interrupt_in, timer_interrupt_in;
  logic        ext_reset_in, aux_irq_switch_pin_out, aux_irq_switch_pin_oe_out, aux_switch_mode_out;
  logic        timer_irq_pin_out, timer_irq_pin_oe_out, clock_out_pin_out, reset_out_pin_out;
  logic        reset_out_pin_oe_out, irq_out, aux_lvl, tmr_lvl, rst_lvl;
  int          num_errors, cmp_count;
  // src {square, combined, alarm, timer}; res {aux level, clock out}
  rops_row_t rows [11] = '{
    '{8'h00, 8'h02, 8'h00, 4'h0, 2'h2},
    '{8'h00, 8'h01, 8'h00, 4'h0, 2'h1},
    '{8'h04, 8'h00, 8'h00, 4'h4, 2'h0},
    '{8'h04, 8'h00, 8'h00, 4'h0, 2'h2},
    '{8'h08, 8'h04, 8'h80, 4'h8, 2'h3},
    '{8'h08, 8'h04, 8'h00, 4'h8, 2'h0},
    '{8'h0c, 8'h00, 8'h00, 4'h2, 2'h0},
    '{8'h10, 8'h00, 8'h00, 4'h1, 2'h2},
    '{8'h14, 8'h00, 8'h00, 4'h1, 2'h0},
    '{8'h18, 8'h02, 8'h00, 4'hf, 2'h2},
    '{8'h24, 8'h00, 8'h00, 4'h0, 2'h0}
  };
  rops_top uut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .square_wave_in(square_wave_in),
    .combined_irq_in(combined_irq_in), .alarm_interrupt_in(alarm_interrupt_in),
    .timer_interrupt_in(timer_interrupt_in), .ext_reset_in(ext_reset_in),
    .aux_irq_switch_pin_out(aux_irq_switch_pin_out), .aux_irq_switch_pin_oe_out(aux_irq_switch_pin_oe_out),
    .aux_switch_mode_out(aux_switch_mode_out), .timer_irq_pin_out(timer_irq_pin_out),
    .timer_irq_pin_oe_out(timer_irq_pin_oe_out), .clock_out_pin_out(clock_out_pin_out),
    .reset_out_pin_out(reset_out_pin_out), .reset_out_pin_oe_out(reset_out_pin_oe_out),
    .irq_out(irq_out));
  rops_host_model host (
    .aux_oe_in(aux_irq_switch_pin_oe_out), .aux_pin_in(aux_irq_switch_pin_out),
    .tmr_oe_in(timer_irq_pin_oe_out), .tmr_pin_in(timer_irq_pin_out),
    .rst_oe_in(reset_out_pin_oe_out), .rst_pin_in(reset_out_pin_out),
    .aux_lvl_out(aux_lvl), .tmr_lvl_out(tmr_lvl), .rst_lvl_out(rst_lvl));
  always #25 mclk_in = ~mclk_in;
  task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic e, input logic g);
    chk_reg({7'h0, e}, {7'h0, g});
  endtask : chk_pin
  // one classic cycle; waits for ack, however long the slave takes
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [7:0] r);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_sel_in <= 4'h1;
    wb_adr_in <= {i, 2'h0};
    wb_dat_in <= {24'h0, d};
    do begin
      @(posedge mclk_in);
    end while (wb_ack_out !== 1'b1);
    r = wb_dat_out[7:0];
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
    @(posedge mclk_in);
  endtask : bus
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, i, d, r);
  endtask : wr
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // watchdog: the whole sequence needs well under 1500 cycles
  initial begin
    repeat (4000) @(posedge mclk_in);
    num_errors++;
    conclude();
  end
  initial begin
    {mclk_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_sel_in, wb_dat_in} = '0;
    {square_wave_in, combined_irq_in, alarm_interrupt_in, timer_interrupt_in} = 4'h0;
    {num_errors, cmp_count} = '0;
    sys_rst_in = 1'b1;
    ext_reset_in = 1'b1;
    repeat (4) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    foreach (rows[i]) begin
      wr(IDX_CONTROL2, rows[i].ctl2);
      wr(IDX_SQCFG, rows[i].sq);
      wr(IDX_CONFIG, rows[i].cfg);
      {square_wave_in, combined_irq_in, alarm_interrupt_in, timer_interrupt_in} <= rows[i].src;
      repeat (4) @(posedge mclk_in);
      chk_pin(rows[i].res[1], aux_lvl);
      chk_pin(rows[i].res[0], clock_out_pin_out);
      chk_pin(!rows[i].src[0], tmr_lvl);
    end
    chk_pin(1'b1, aux_switch_mode_out);
    // second reset in mid-run: polarity back to zero, reset line released
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    bus(1'b0, IDX_CONFIG, 8'h00, rd);
    chk_reg(CONFIG_RST, rd);
    chk_pin(1'b1, rst_lvl);
    chk_pin(1'b0, aux_switch_mode_out);
    wr(IDX_CONFIG, 8'h10);
    ext_reset_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    chk_pin(1'b0, rst_lvl);
    wr(IDX_CONFIG, 8'h18);
    repeat (4) @(posedge mclk_in);
    chk_pin(1'b1, rst_lvl);
    ext_reset_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    chk_pin(1'b0, rst_lvl);
    // interrupt: raise, mask, unmask, clear while the source stays high
    bus(1'b0, IDX_STATUS, 8'h00, rd);
    chk_reg(8'h01, rd);
    wr(IDX_STATUS, 8'h07);
    wr(IDX_MASK, 8'h02);
    timer_interrupt_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk_pin(1'b1, irq_out);
    bus(1'b0, IDX_STATUS, 8'h00, rd);
    chk_reg(8'h02, rd);
    wr(IDX_MASK, 8'h00);
    chk_pin(1'b0, irq_out);
    wr(IDX_MASK, 8'h02);
    chk_pin(1'b1, irq_out);
    wr(IDX_STATUS, 8'h02);
    chk_pin(1'b0, irq_out);
    // unmapped place reads zero and a write there changes nothing
    wr(6'h3f, 8'hff);
    bus(1'b0, 6'h3f, 8'h00, rd);
    chk_reg(8'h00, rd);
    bus(1'b0, IDX_MASK, 8'h00, rd);
    chk_reg(8'h02, rd);
    conclude();
  end
endmodule : tb
